// File: rtl/asg_pkg.sv
package asg_pkg;
   localparam int PORT_W = 8;
   localparam logic [3:0] BANK_FG = 4'h5;
   localparam logic [3:0] BANK_H = 4'h8;
   localparam logic [7:0] OFS_F_DIR = 8'h10;
   localparam logic [7:0] OFS_F_DATA = 8'h11;
   localparam logic [7:0] OFS_G_DIR = 8'h12;
   localparam logic [7:0] OFS_G_DATA = 8'h13;
   localparam logic [7:0] OFS_CONV_CTL = 8'h15;
   localparam logic [7:0] OFS_H_DIR = 8'h10;
   localparam logic [7:0] OFS_H_DATA = 8'h11;
   localparam logic [7:0] RST_DIR = 8'hff;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_CONV_CTL = 8'h00;
   localparam logic [7:0] CONV_CTL_MASK = 8'hef;
   localparam logic [3:0] PCFG_ALL_DIGITAL = 4'he;
   localparam int PCFG_LSB = 0;
   localparam int F_CH_BASE = 4;
   localparam int H_CH_BASE = 12;
   localparam int ANALOG_CH = 16;
endpackage

// File: rtl/asg_pin_if.sv
interface asg_pin_if;
   logic [7:0] dir;
   logic [7:0] latch;
   logic [7:0] analog;
   logic [7:0] pin_in;
   logic [7:0] pin_out;
   logic [7:0] pin_oe;
   logic [7:0] read_val;
   modport ctl (output dir, latch, analog, input read_val, pin_out, pin_oe);
   modport pad (input dir, latch, analog, pin_in,
                output read_val, pin_out, pin_oe);
endinterface

// File: rtl/asg_pad_bank.sv
module asg_pad_bank (
   asg_pin_if.pad p
);
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         // analog pins neither drive nor read
         assign p.pin_oe[i] = ~p.dir[i] & ~p.analog[i];
         assign p.pin_out[i] = p.latch[i];
         assign p.read_val[i] = p.analog[i] ? 1'b0 : p.pin_in[i];
      end
   endgenerate
endmodule

// File: rtl/asg_ports.sv
// What this block does
// - direction one makes input, zero drives the latch out
// - data reads return pin levels; writes load only the latch
// - port f bit n carries analog channel n+4
// - reset leaves all port f pins analog
// - port g bits 0..3 carry channels 3..0 reversed
// - port g bit 2 negative reference, bit 3 positive reference
// - port g bit 4 capture three in, bit 5 pwm three out
// - port g bits 6,7 carry serial two data and clock
// - reset leaves port g bits 3..0 analog
// - port h bits 4..7 carry channels 12..15, low nibble digital
// - reset leaves port h bits 7..4 analog
// - all direction registers reset to all ones
module asg_ports
   import asg_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // banked register access
   input wire logic [3:0] BANK,
   input wire logic [7:0] ADDR,
   input wire logic WR_EN,
   input wire logic RD_EN,
   input wire logic [7:0] WR_DATA,
   output logic [7:0] RD_DATA,
   output logic RD_HIT,
   // pins
   input wire logic [7:0] F_IN,
   output logic [7:0] F_OUT,
   output logic [7:0] F_OE,
   input wire logic [7:0] G_IN,
   output logic [7:0] G_OUT,
   output logic [7:0] G_OE,
   input wire logic [7:0] H_IN,
   output logic [7:0] H_OUT,
   output logic [7:0] H_OE,
   // converter side
   output logic [15:0] ANALOG_EN,
   output logic [3:0] PORT_CONFIG,
   output logic CONV_CLK_SEL_HIGH,
   output logic CONV_CLK_SEL_LOW,
   output logic RESULT_FORMAT,
   output logic VREF_NEG_EN,
   output logic VREF_POS_EN,
   // peripheral sharing
   input wire logic CAPTURE_THREE_INPUT_ENABLE,
   output logic CAPTURE_THREE_INPUT_IN,
   input wire logic PULSE_WIDTH_THREE_OUTPUT_ENABLE,
   input wire logic PULSE_WIDTH_THREE_OUTPUT_OUT,
   input wire logic SER2_ENABLE,
   input wire logic SER2_DATA_OUT,
   input wire logic SER2_DATA_OE,
   output logic SER2_DATA_IN,
   input wire logic SER2_CLK_OUT,
   input wire logic SER2_CLK_OE,
   output logic SER2_CLK_IN,
   // converter asks to use the reference pins
   input wire logic VREF_USE_PINS
);
   logic [7:0] f_dir_reg, g_dir_reg, h_dir_reg;
   logic [7:0] f_lat_reg, g_lat_reg, h_lat_reg;
   logic [7:0] conv_ctl_reg;
   logic [7:0] rd_next;
   logic hit_next;
   logic [3:0] pcfg;
   logic [7:0] f_an, g_an, h_an;
   logic sel_fg, sel_h;

   asg_pin_if pf();
   asg_pin_if pg();
   asg_pin_if ph();

   // bank 5 for f, g and the converter control, bank 8 for h
   assign sel_fg = (BANK == BANK_FG);
   assign sel_h = (BANK == BANK_H);

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         f_dir_reg <= RST_DIR;
         g_dir_reg <= RST_DIR;
         h_dir_reg <= RST_DIR;
      end else if (WR_EN) begin
         if (sel_fg && ADDR == OFS_F_DIR) begin
            f_dir_reg <= WR_DATA;
         end else if (sel_fg && ADDR == OFS_G_DIR) begin
            g_dir_reg <= WR_DATA;
         end else if (sel_h && ADDR == OFS_H_DIR) begin
            h_dir_reg <= WR_DATA;
         end
      end
   end

   // writes to a data address only reach the latch
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         f_lat_reg <= RST_LATCH;
         g_lat_reg <= RST_LATCH;
         h_lat_reg <= RST_LATCH;
      end else if (WR_EN) begin
         if (sel_fg && ADDR == OFS_F_DATA) begin
            f_lat_reg <= WR_DATA;
         end else if (sel_fg && ADDR == OFS_G_DATA) begin
            g_lat_reg <= WR_DATA;
         end else if (sel_h && ADDR == OFS_H_DATA) begin
            h_lat_reg <= WR_DATA;
         end
      end
   end

   // reset value selects all shared pins analog
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         conv_ctl_reg <= RST_CONV_CTL;
      end else if (WR_EN && sel_fg && ADDR == OFS_CONV_CTL) begin
         conv_ctl_reg <= WR_DATA & CONV_CTL_MASK;
      end
   end

   assign pcfg = conv_ctl_reg[PCFG_LSB +: 4];
   // only the all-digital code releases the pins; other codes are analog
   // here, a simplification of the converter's per-channel table
   assign f_an = (pcfg == PCFG_ALL_DIGITAL) ? 8'h00 : 8'hff;
   assign g_an = (pcfg == PCFG_ALL_DIGITAL) ? 8'h00 : 8'h0f;
   assign h_an = (pcfg == PCFG_ALL_DIGITAL) ? 8'h00 : 8'hf0;

   assign pf.dir = f_dir_reg;
   assign pf.latch = f_lat_reg;
   assign pf.analog = f_an;
   assign pf.pin_in = F_IN;
   assign ph.dir = h_dir_reg;
   assign ph.latch = h_lat_reg;
   assign ph.analog = h_an;
   assign ph.pin_in = H_IN;
   assign pg.dir = g_dir_reg;
   assign pg.analog = g_an;
   assign pg.pin_in = G_IN;

   // peripheral drive overrides the latch on port g bits 5 to 7
   always_comb begin
      pg.latch = g_lat_reg;
      if (PULSE_WIDTH_THREE_OUTPUT_ENABLE) begin
         pg.latch[5] = PULSE_WIDTH_THREE_OUTPUT_OUT;
      end
      if (SER2_ENABLE) begin
         pg.latch[6] = SER2_DATA_OUT;
         pg.latch[7] = SER2_CLK_OUT;
      end
   end

   asg_pad_bank u_f (.p(pf.pad));
   asg_pad_bank u_g (.p(pg.pad));
   asg_pad_bank u_h (.p(ph.pad));

   assign F_OUT = pf.pin_out;
   assign F_OE = pf.pin_oe;
   assign H_OUT = ph.pin_out;
   assign H_OE = ph.pin_oe;
   assign G_OUT = pg.pin_out;

   always_comb begin
      G_OE = pg.pin_oe;
      if (PULSE_WIDTH_THREE_OUTPUT_ENABLE) begin
         G_OE[5] = 1'b1;
      end
      if (SER2_ENABLE) begin
         G_OE[6] = SER2_DATA_OE;
         G_OE[7] = SER2_CLK_OE;
      end
   end

   // input peripherals see the raw pin only when enabled; else capture reads 0, serial reads 1
   assign CAPTURE_THREE_INPUT_IN = CAPTURE_THREE_INPUT_ENABLE ? G_IN[4] : 1'b0;
   assign SER2_DATA_IN = SER2_ENABLE ? G_IN[6] : 1'b1;
   assign SER2_CLK_IN = SER2_ENABLE ? G_IN[7] : 1'b1;

   genvar n;
   generate
      for (n = 0; n < 8; n++) begin : g_fch
         assign ANALOG_EN[F_CH_BASE + n] = f_an[n];
      end
      for (n = 0; n < 4; n++) begin : g_gch
         assign ANALOG_EN[3 - n] = g_an[n];
         assign ANALOG_EN[H_CH_BASE + n] = h_an[4 + n];
      end
   endgenerate

   // reference pins only when analog and the converter asks for them
   assign VREF_NEG_EN = g_an[2] & VREF_USE_PINS;
   assign VREF_POS_EN = g_an[3] & VREF_USE_PINS;
   assign PORT_CONFIG = pcfg;
   assign CONV_CLK_SEL_HIGH = conv_ctl_reg[7];
   assign CONV_CLK_SEL_LOW = conv_ctl_reg[6];
   assign RESULT_FORMAT = conv_ctl_reg[5];

   // pins sampled at the read request, answered one cycle later
   always_comb begin
      rd_next = 8'h00;
      hit_next = 1'b1;
      if (sel_fg && ADDR == OFS_F_DIR) begin
         rd_next = f_dir_reg;
      end else if (sel_fg && ADDR == OFS_F_DATA) begin
         rd_next = pf.read_val;
      end else if (sel_fg && ADDR == OFS_G_DIR) begin
         rd_next = g_dir_reg;
      end else if (sel_fg && ADDR == OFS_G_DATA) begin
         rd_next = pg.read_val;
      end else if (sel_fg && ADDR == OFS_CONV_CTL) begin
         rd_next = conv_ctl_reg;
      end else if (sel_h && ADDR == OFS_H_DIR) begin
         rd_next = h_dir_reg;
      end else if (sel_h && ADDR == OFS_H_DATA) begin
         rd_next = ph.read_val;
      end else begin
         hit_next = 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         RD_DATA <= 8'h00;
         RD_HIT <= 1'b0;
      end else if (RD_EN) begin
         RD_DATA <= rd_next;
         RD_HIT <= hit_next;
      end else begin
         RD_HIT <= 1'b0;
      end
   end
endmodule

// File: testbench/asg_board.sv
// board side of one port: a driven pin follows the drive, else the board
module asg_board (
   // pad
   input wire logic [7:0] oe,
   input wire logic [7:0] drv,
   input wire logic [7:0] ext,
   output logic [7:0] pin
);
   timeunit 1ns;
   timeprecision 1ns;
   assign pin = (oe & drv) | (~oe & ext);
endmodule

// File: testbench/asg_ports_chk.sv
module asg_ports_chk
   import asg_pkg::*;
(
   // watched ports, grouped to stay short
   input wire logic CLOCK, RST_N, WR_EN, RD_EN, RD_HIT,
   input wire logic [3:0] BANK,
   input wire logic [7:0] ADDR, WR_DATA, RD_DATA, F_IN, F_OE, G_IN, G_OE,
   input wire logic [7:0] H_OE,
   input wire logic [15:0] ANALOG_EN,
   input wire logic VREF_NEG_EN, VREF_USE_PINS, CAPTURE_THREE_INPUT_ENABLE, CAPTURE_THREE_INPUT_IN,
   input wire logic SER2_ENABLE, SER2_DATA_IN
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   wire logic fg = BANK == BANK_FG;
   wire logic [7:0] f_ana = ANALOG_EN[11:4];
   a_reset_analog: assert property
      ($rose(RST_N) |-> &ANALOG_EN) else $error("not analog after reset");
   a_dir_input: assert property (WR_EN && fg && ADDR == OFS_F_DIR
      |=> (F_OE & $past(WR_DATA)) == 8'h00) else $error("input driven");
   a_f_analog: assert property ((F_OE & f_ana) == 8'h00)
      else $error("analog f pin driven");
   a_g_reversed: assert property ((G_OE[3:0] & {ANALOG_EN[0],
      ANALOG_EN[1], ANALOG_EN[2], ANALOG_EN[3]}) == 4'h0) else $error("g");
   a_h_analog: assert property ((H_OE[7:4] & ANALOG_EN[15:12]) == 4'h0)
      else $error("analog h pin driven");
   a_read_pins: assert property (RD_EN && fg && ADDR == OFS_F_DATA
      |=> RD_HIT && RD_DATA == ($past(F_IN) & ~$past(f_ana)))
      else $error("f read");
   a_read_refused: assert property (RD_EN && BANK == 4'h3
      |=> !RD_HIT && RD_DATA == 8'h00) else $error("refused read");
   a_vref_neg: assert property
      (VREF_NEG_EN == (ANALOG_EN[1] && VREF_USE_PINS)) else $error("vref");
   a_cap_route: assert property (CAPTURE_THREE_INPUT_ENABLE |-> CAPTURE_THREE_INPUT_IN == G_IN[4])
      else $error("capture");
   a_ser_route: assert property (SER2_ENABLE |-> SER2_DATA_IN == G_IN[6])
      else $error("serial");
   c_read: cover property (RD_HIT);
   c_digital: cover property (ANALOG_EN == 16'h0000);
   c_cap: cover property (CAPTURE_THREE_INPUT_ENABLE && CAPTURE_THREE_INPUT_IN);
endmodule
bind asg_ports asg_ports_chk i_chk (.*);

// File: testbench/testbench.sv
module testbench import asg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLOCK = 0, RST_N = 0, WR_EN = 0, RD_EN = 0, RD_HIT;
   logic [3:0] BANK = 4'h5, PORT_CONFIG;
   logic [7:0] ADDR = 8'h00, WR_DATA = 8'h00, RD_DATA, ext = 8'h33;
   logic [7:0] F_IN, F_OUT, F_OE, G_IN, G_OUT, G_OE, H_IN, H_OUT, H_OE;
   logic [15:0] ANALOG_EN;
   logic CONV_CLK_SEL_HIGH, CONV_CLK_SEL_LOW, RESULT_FORMAT, VREF_NEG_EN;
   logic VREF_POS_EN, CAPTURE_THREE_INPUT_IN, SER2_DATA_IN, SER2_CLK_IN, VREF_USE_PINS = 1;
   logic CAPTURE_THREE_INPUT_ENABLE = 0, PULSE_WIDTH_THREE_OUTPUT_ENABLE = 0, PULSE_WIDTH_THREE_OUTPUT_OUT = 0, SER2_ENABLE = 0;
   logic SER2_DATA_OUT = 0, SER2_DATA_OE = 0, SER2_CLK_OUT = 1;
   logic SER2_CLK_OE = 1;
   logic [3:0] bk[3] = '{BANK_FG, BANK_FG, BANK_H};
   logic [7:0] da[3] = '{OFS_F_DATA, OFS_G_DATA, OFS_H_DATA};
   logic [7:0] di[3] = '{OFS_F_DIR, OFS_G_DIR, OFS_H_DIR};
   int failures = 0, checks = 0;
   always #5 CLOCK = ~CLOCK;
   asg_ports i_dut (.*);
   asg_board i_bf (.oe(F_OE), .drv(F_OUT), .ext(ext), .pin(F_IN));
   asg_board i_bg (.oe(G_OE), .drv(G_OUT), .ext(ext), .pin(G_IN));
   asg_board i_bh (.oe(H_OE), .drv(H_OUT), .ext(ext), .pin(H_IN));
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [3:0] b, logic [7:0] a, logic [7:0] d);
      @(negedge CLOCK);
      {BANK, ADDR, WR_DATA, WR_EN} = {b, a, d, 1'b1};
      @(negedge CLOCK);
      WR_EN = 0;
   endtask
   task automatic rd(logic [3:0] b, logic [7:0] a, logic [7:0] e, logic h);
      @(negedge CLOCK);
      {BANK, ADDR, RD_EN} = {b, a, 1'b1};
      @(negedge CLOCK);
      RD_EN = 0;
      chk("read", {7'h00, h, e}, {7'h00, RD_HIT, RD_DATA});
   endtask
   task automatic end_of_test;
      $display("failures %0d checks %0d", failures, checks);
      if (failures == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // every wait is a fixed cycle count; this only guards the whole run
   initial begin
      #100000;
      failures++;
      end_of_test;
   end
   initial begin
      repeat (5) @(negedge CLOCK);
      RST_N = 1;
      rd(BANK_FG, OFS_F_DIR, RST_DIR, 1);
      rd(BANK_FG, OFS_G_DIR, RST_DIR, 1);
      rd(BANK_H, OFS_H_DIR, RST_DIR, 1);
      rd(BANK_FG, OFS_CONV_CTL, RST_CONV_CTL, 1);
      chk("analog", 16'hffff, ANALOG_EN);
      rd(BANK_FG, OFS_F_DATA, 8'h00, 1);
      rd(4'h3, OFS_F_DIR, 8'h00, 0);
      rd(BANK_FG, 8'h14, 8'h00, 0);
      wr(BANK_FG, OFS_CONV_CTL, 8'hfe);
      rd(BANK_FG, OFS_CONV_CTL, 8'hee, 1);
      chk("analog", 16'h0000, ANALOG_EN);
      chk("conv ctl", 16'h00ee, {8'h00, CONV_CLK_SEL_HIGH, CONV_CLK_SEL_LOW,
         RESULT_FORMAT, 1'b0, PORT_CONFIG});
      foreach (bk[i]) begin
         wr(bk[i], da[i], 8'h00);
         wr(bk[i], da[i], 8'h5a);
         wr(bk[i], di[i], 8'h0f);
         rd(bk[i], da[i], 8'h53, 1);
         rd(bk[i], di[i], 8'h0f, 1);
      end
      wr(BANK_FG, OFS_CONV_CTL, 8'h00);
      chk("g drive", 16'h00f0, {8'h00, G_OE});
      chk("h drive", 16'h0000, {8'h00, H_OE});
      chk("vref", 16'h0003, {14'h0, VREF_POS_EN, VREF_NEG_EN});
      rd(BANK_FG, OFS_G_DATA, 8'h50, 1);
      rd(BANK_H, OFS_H_DATA, 8'h03, 1);
      {CAPTURE_THREE_INPUT_ENABLE, PULSE_WIDTH_THREE_OUTPUT_ENABLE, SER2_ENABLE} = 3'b111;
      #1;
      chk("share", 16'h0016, {11'h0, CAPTURE_THREE_INPUT_IN, SER2_DATA_IN, SER2_CLK_IN,
         G_OE[5], G_OUT[5]});
      RST_N = 0;
      @(negedge CLOCK);
      RST_N = 1;
      rd(BANK_FG, OFS_G_DIR, RST_DIR, 1);
      end_of_test;
   end
endmodule
